// ### bench/scsr_bridge_monitor.sv
// port assertions for scsr_bridge, attached by bind
// assumes host strobes are one cycle wide and spaced by an idle cycle
`timescale 1ns/1ps
`default_nettype none
`include "scsr_regs.svh"
module scsr_bridge_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`SCSR_HOST_AW-1:0] hostAddr,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [31:0] hostWdata,
   input wire logic [31:0] hostRdata,
   input wire logic hostRdValid,
   input wire logic fabReq,
   input wire scsr_pkg::scsr_fab_req_t fabReqInfo,
   input wire logic fabAck,
   input wire logic [31:0] fabRdata
);
   import scsr_pkg::*;
   logic [15:0] winAddr;
   logic [3:0] be;
   logic [31:0] keepMask;
   assign be = fabReqInfo.byteLaneEnables;
   assign keepMask = ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   always_ff @(posedge clk) begin
      if (hostWrite) winAddr <= `SCSR_WIN_FAB_BASE + {9'h0, hostAddr[8:2]};
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // a start only counts where no earlier access can still hold pending
   sequence quietHost; !fabReq && !$past(hostWrite) && !$past(hostRead); endsequence
   sequence cmdStart; hostWrite && hostAddr == `SCSR_CMD_OFS && hostWdata[31] ##0 quietHost; endsequence
   sequence winStart; hostWrite && hostAddr[11:9] == `SCSR_WIN_SEL ##0 quietHost; endsequence
   sequence fetchThenWrite; fabReq && fabAck && !fabReqInfo.writeEn ##1 fabReq && fabReqInfo.writeEn; endsequence
   cmd_launch_a: assert property (cmdStart |-> ##2 fabReq && fabReqInfo.addr == $past(hostWdata[15:0], 2)
      && fabReqInfo.writeEn == (!$past(hostWdata[30], 2) && $past(hostWdata[19:16], 2) == 4'hf)) else $error("bad launch");
   win_launch_a: assert property (winStart |-> ##[1:3] fabReq && fabReqInfo.writeEn && fabReqInfo.addr == winAddr
      && be == `SCSR_BE_ALL) else $error("window write not launched");
   lane_merge_a: assert property (fetchThenWrite |-> ((fabReqInfo.wdata ^ $past(fabRdata)) & keepMask) == 32'h0)
      else $error("disabled lanes not kept");
   write_done_a: assert property (fabReq && fabAck && fabReqInfo.writeEn |=> !fabReq) else $error("request after write");
   req_held_a: assert property (fabReq && !fabAck |=> fabReq && $stable(fabReqInfo)) else $error("request moved");
   rd_valid_a: assert property (hostRead |=> hostRdValid) else $error("read not answered");
   rd_quiet_a: assert property (!hostRead |=> !hostRdValid) else $error("valid without read");
   rdata_hold_a: assert property (!hostRdValid |-> $stable(hostRdata)) else $error("read data moved");
endmodule : scsr_bridge_monitor
bind scsr_bridge scsr_bridge_monitor u_monitor (.clk, .rst, .hostAddr, .hostWrite, .hostRead, .hostWdata,
   .hostRdata, .hostRdValid, .fabReq, .fabReqInfo, .fabAck, .fabRdata);
`default_nettype wire

// ### bench/scsr_fabric_model.sv
// fabric register space behind the bridge
// acks after lat wait cycles; read lines carry junk outside the ack cycle
`timescale 1ns/1ps
`default_nettype none
module scsr_fabric_model (
   input wire logic clk,
   input wire logic fabReq,
   input wire scsr_pkg::scsr_fab_req_t fabReqInfo,
   input wire logic [3:0] lat,
   output logic fabAck,
   output logic [31:0] fabRdata
);
   import scsr_pkg::*;
   logic [31:0] mem [256];
   logic [3:0] waitCnt = 4'h0;
   logic [7:0] a;
   initial for (int i = 0; i < 256; i++) mem[i] = 32'h0101_0101 * i;
   assign a = fabReqInfo.addr[7:0];
   assign fabAck = fabReq && waitCnt == lat;
   assign fabRdata = fabAck ? mem[a] : ~mem[a];
   always @(posedge clk) begin
      waitCnt <= (fabAck || !fabReq) ? 4'h0 : waitCnt + 4'h1;
      for (int b = 0; b < 4; b++)
         if (fabAck && fabReqInfo.writeEn && be(b)) mem[a][b*8+:8] <= fabReqInfo.wdata[b*8+:8];
   end
   function automatic logic be(input int b);
      return fabReqInfo.byteLaneEnables[b];
   endfunction : be
endmodule : scsr_fabric_model
`default_nettype wire

// ### bench/switch_csr_indirect_access_test.sv
// self-checking bench for scsr_bridge with the fabric model behind it
// host port driven at the falling edge; fabric word i starts as 01010101h * i
`timescale 1ns/1ps
`default_nettype none
`include "scsr_regs.svh"
module switch_csr_indirect_access_test;
   import scsr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hostWrite = 1'b0;
   logic hostRead = 1'b0;
   logic [11:0] hostAddr = 12'h000;
   logic [31:0] hostWdata = 32'h0;
   logic [3:0] lat = 4'h2;
   logic hostRdValid, fabReq, fabAck;
   logic [31:0] hostRdata, fabRdata, rd;
   scsr_fab_req_t fabReqInfo;
   int err_count = 0;
   int checked = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   scsr_bridge u_dut (.clk, .rst, .hostAddr, .hostWrite, .hostRead, .hostWdata, .hostRdata, .hostRdValid,
      .fabReq, .fabReqInfo, .fabAck, .fabRdata);
   scsr_fabric_model u_fabric (.clk, .fabReq, .fabReqInfo, .lat, .fabAck, .fabRdata);
   function automatic logic [31:0] initVal(input logic [7:0] a);
      return 32'h0101_0101 * a;
   endfunction : initVal
   task conclude;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task hw(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk);
      hostAddr = a;
      hostWdata = d;
      hostWrite = 1'b1;
      @(negedge clk);
      hostWrite = 1'b0;
   endtask : hw
   task hr(input logic [11:0] a);
      @(negedge clk);
      hostAddr = a;
      hostRead = 1'b1;
      @(negedge clk);
      hostRead = 1'b0;
      rd = hostRdata;
   endtask : hr
   // poll the pending flag; each poll already spans the read-after-write gap
   task waitIdle;
      for (int i = 0; i < 40; i++) begin
         hr(`SCSR_CMD_OFS);
         if (rd[31] === 1'b0) break;
      end
   endtask : waitIdle
   task rdFab(input logic [7:0] a);
      hw(`SCSR_CMD_OFS, {24'hc00000, a});
      waitIdle();
      hr(`SCSR_DATA_OFS);
   endtask : rdFab
   task t_reset;
      hr(`SCSR_CMD_OFS);
      check(rd, `SCSR_CMD_RESET);
      hr(`SCSR_DATA_OFS);
      check(rd, `SCSR_DATA_RESET);
   endtask : t_reset
   task t_single;
      lat = 4'h3;
      hw(`SCSR_DATA_OFS, 32'hcafe_0001);
      hw(`SCSR_CMD_OFS, 32'h800f_0010);
      waitIdle();
      check(rd, 32'h000f_0010);
      rdFab(8'h10);
      check(rd, 32'hcafe_0001);
      lat = 4'h9;
      hw(`SCSR_DATA_OFS, 32'h1122_3344);
      hw(`SCSR_CMD_OFS, 32'h8005_0011);
      hw(`SCSR_DATA_OFS, 32'hffff_ffff);
      waitIdle();
      rdFab(8'h11);
      check(rd, (initVal(8'h11) & 32'hff00_ff00) | 32'h0022_0044);
   endtask : t_single
   task t_step_write;
      lat = 4'h0;
      hw(`SCSR_CMD_OFS, 32'h002f_0020);
      hw(`SCSR_DATA_OFS, 32'haaaa_0020);
      waitIdle();
      check(rd, 32'h002f_0021);
      hw(`SCSR_DATA_OFS, 32'haaaa_0021);
      waitIdle();
      check(rd, 32'h002f_0022);
      hw(`SCSR_CMD_OFS, 32'h001f_0030);
      hw(`SCSR_DATA_OFS, 32'haaaa_0030);
      waitIdle();
      check(rd, 32'h001f_002f);
      rdFab(8'h21);
      check(rd, 32'haaaa_0021);
      rdFab(8'h30);
      check(rd, 32'haaaa_0030);
   endtask : t_step_write
   task t_step_read;
      lat = 4'h5;
      hw(`SCSR_CMD_OFS, 32'hc010_0042);
      waitIdle();
      check(rd, 32'h4010_0042);
      hr(`SCSR_DATA_OFS);
      check(rd, initVal(8'h42));
      waitIdle();
      check(rd, 32'h4010_0041);
      hw(`SCSR_CMD_OFS, 32'h4000_0041);
      hr(`SCSR_DATA_OFS);
      check(rd, initVal(8'h41));
      hr(`SCSR_CMD_OFS);
      check(rd, 32'h4000_0041);
   endtask : t_step_read
   task t_window;
      lat = 4'h1;
      hw(12'h208, 32'h5a5a_0002);
      waitIdle();
      check(rd, 32'h000f_0002);
      hw(12'h3fc, 32'h5a5a_007f);
      waitIdle();
      check(rd, 32'h000f_007f);
      rdFab(8'h02);
      check(rd, 32'h5a5a_0002);
   endtask : t_window
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_single();
      t_step_write();
      t_step_read();
      t_window();
      conclude();
   end
endmodule : switch_csr_indirect_access_test
`default_nettype wire

// ### inc/scsr_pkg.sv
// types shared by the fabric indirect access bridge
// field layout matches the bit positions in scsr_regs.svh
package scsr_pkg;

   typedef struct packed {
      logic pending;
      logic readNotWrite;
      logic [7:0] reserved;
      logic stepUp;
      logic stepDown;
      logic [3:0] byteLaneEnables;
      logic [15:0] targetRegAddr;
   } scsr_cmd_t;

   typedef struct packed {
      logic writeEn;
      logic [3:0] byteLaneEnables;
      logic [15:0] addr;
      logic [31:0] wdata;
   } scsr_fab_req_t;

   typedef enum logic [1:0] {
      SCSR_IDLE = 2'b00,
      SCSR_FETCH_OLD = 2'b01,
      SCSR_WRITE = 2'b10,
      SCSR_READ = 2'b11
   } scsr_state_t;

endpackage : scsr_pkg

// ### inc/scsr_regs.svh
// constants for the fabric indirect access bridge: offsets, field positions, resets
// assumes a 12-bit word-aligned host register port
`ifndef SCSR_REGS_SVH
`define SCSR_REGS_SVH

`define SCSR_HOST_AW 12
`define SCSR_DATA_OFS 12'h000
`define SCSR_CMD_OFS 12'h004
`define SCSR_WIN_SEL 3'h1
`define SCSR_WIN_FAB_BASE 16'h0000

`define SCSR_PEND_BIT 31
`define SCSR_RNW_BIT 30
`define SCSR_UP_BIT 21
`define SCSR_DOWN_BIT 20
`define SCSR_BE_HI 19
`define SCSR_BE_LO 16
`define SCSR_ADDR_HI 15
`define SCSR_ADDR_LO 0

`define SCSR_BE_ALL 4'hf
`define SCSR_CMD_RESET 32'h0000_0000
`define SCSR_DATA_RESET 32'h0000_0000

`endif

// ### rtl/scsr_bridge.sv
// indirect access bridge from host system registers to fabric config/status registers
// assumes a single-cycle host register port and a fabric port that acks each request once
//
// Function
// (R1) the host loads the data register before a single write command.
// (R2) a command write with pending set, read_not_write clear and no stepping starts one write with its byte enables.
// (R3) pending clears when the fabric write has completed.
// (R4) with a stepping bit set for writes, each host data write launches one fabric write.
// (R5) after a stepped write completes the command address moves up or down by one.
// (R6) the host issues each further stepped write only after the previous one finished.
// (R7) a write to the direct window sets the mapped address, all byte enables, write direction and pending.
// (R8) the direct window covers only a subset of the fabric space; the rest needs the command register.
// (R9) a command write with pending and read_not_write set and no stepping starts one fabric read.
// (R10) pending clears only once the read value sits in the data register; host reads data after that.
// (R11) with a stepping bit set for reads, each completed fetch clears pending.
// (R12) in stepped read mode each host data read steps the address and launches the next fetch.
// (R13) the host should clear both stepping bits before reading the last word of a stepped read.
// (R14) the host keeps the read-after-write wait times at the marked points of the sequences.
// (R15) the host starts no new transfer while pending is still set.
// (R16) a write updates only the byte lanes whose enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "scsr_regs.svh"

module scsr_bridge (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`SCSR_HOST_AW-1:0] hostAddr,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [31:0] hostWdata,
   output logic [31:0] hostRdata,
   output logic hostRdValid,
   output logic fabReq,
   output scsr_pkg::scsr_fab_req_t fabReqInfo,
   input wire logic fabAck,
   input wire logic [31:0] fabRdata
);
   import scsr_pkg::*;

   scsr_state_t state;
   scsr_state_t next_state;
   scsr_cmd_t cmd;
   scsr_cmd_t next_cmd;
   logic [31:0] dataReg;
   logic [31:0] next_dataReg;
   logic [31:0] next_hostRdata;
   logic next_hostRdValid;
   scsr_fab_req_t next_fabReqInfo;
   logic [31:0] mergedWord;
   logic hitData;
   logic hitCmd;
   logic hitWin;
   logic stepping;
   logic [15:0] steppedAddr;
   logic [15:0] winFabAddr;

   assign hitData = (hostAddr == `SCSR_DATA_OFS);
   assign hitCmd = (hostAddr == `SCSR_CMD_OFS);
   // window is 128 words; fabric registers beyond it stay reachable only by command
   assign hitWin = (hostAddr[`SCSR_HOST_AW-1:9] == `SCSR_WIN_SEL); // (R8)
   assign winFabAddr = `SCSR_WIN_FAB_BASE + {9'h000, hostAddr[8:2]}; // (R8)
   assign stepping = cmd.stepUp | cmd.stepDown;
   // up wins when software sets both stepping bits
   assign steppedAddr = cmd.stepUp ? cmd.targetRegAddr + 16'h0001 : cmd.targetRegAddr - 16'h0001;

   // old word comes straight from the fabric answer of the fetch phase
   scsr_lane_merge #(
      .LANES(4)
   ) u_merge (
      .oldWord(fabRdata),
      .newWord(dataReg),
      .laneEn(cmd.byteLaneEnables),
      .merged(mergedWord)
   );

   // request stays up until the fabric acks
   assign fabReq = (state != SCSR_IDLE);

   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_dataReg = dataReg;
      next_hostRdata = hostRdata;
      next_hostRdValid = 1'b0;
      next_fabReqInfo = fabReqInfo;

      case (state)
         SCSR_IDLE: begin
            if (cmd.pending) begin
               next_fabReqInfo.addr = cmd.targetRegAddr;
               next_fabReqInfo.byteLaneEnables = cmd.byteLaneEnables;
               if (cmd.readNotWrite) begin
                  next_fabReqInfo.writeEn = 1'b0; // (R9)
                  next_state = SCSR_READ;
               end else if (cmd.byteLaneEnables == `SCSR_BE_ALL) begin
                  next_fabReqInfo.writeEn = 1'b1; // (R2)
                  next_fabReqInfo.wdata = dataReg;
                  next_state = SCSR_WRITE;
               end else begin
                  // partial lanes: fetch the old word first so untouched lanes survive
                  next_fabReqInfo.writeEn = 1'b0; // (R16)
                  next_state = SCSR_FETCH_OLD;
               end
            end
         end
         SCSR_FETCH_OLD: begin
            if (fabAck) begin
               next_fabReqInfo.writeEn = 1'b1;
               next_fabReqInfo.wdata = mergedWord; // (R16)
               next_state = SCSR_WRITE;
            end
         end
         SCSR_WRITE: begin
            if (fabAck) begin
               next_cmd.pending = 1'b0; // (R3)
               if (stepping) begin
                  next_cmd.targetRegAddr = steppedAddr; // (R5)
               end
               next_fabReqInfo.writeEn = 1'b0;
               next_state = SCSR_IDLE;
            end
         end
         SCSR_READ: begin
            if (fabAck) begin
               next_dataReg = fabRdata; // (R10)
               next_cmd.pending = 1'b0; // (R10) (R11)
               next_state = SCSR_IDLE;
            end
         end
         default: begin
            next_state = SCSR_IDLE;
         end
      endcase

      // host accesses; while pending is set, all command, data and window writes are dropped
      if (hostWrite) begin
         if (hitCmd && !cmd.pending) begin
            next_cmd.pending = hostWdata[`SCSR_PEND_BIT]; // (R2) (R9)
            next_cmd.readNotWrite = hostWdata[`SCSR_RNW_BIT];
            next_cmd.reserved = 8'h00;
            next_cmd.stepUp = hostWdata[`SCSR_UP_BIT]; // (R4) (R11)
            next_cmd.stepDown = hostWdata[`SCSR_DOWN_BIT];
            next_cmd.byteLaneEnables = hostWdata[`SCSR_BE_HI:`SCSR_BE_LO]; // (R2)
            next_cmd.targetRegAddr = hostWdata[`SCSR_ADDR_HI:`SCSR_ADDR_LO];
         end else if (hitData && !cmd.pending) begin
            next_dataReg = hostWdata;
            if (stepping && !cmd.readNotWrite) begin
               next_cmd.pending = 1'b1; // (R4)
            end
         end else if (hitWin && !cmd.pending) begin
            next_dataReg = hostWdata;
            next_cmd.targetRegAddr = winFabAddr; // (R7)
            next_cmd.byteLaneEnables = `SCSR_BE_ALL; // (R7)
            next_cmd.readNotWrite = 1'b0; // (R7)
            next_cmd.pending = 1'b1; // (R7)
         end
      end

      if (hostRead) begin
         next_hostRdValid = 1'b1;
         if (hitData) begin
            next_hostRdata = dataReg;
            if (!cmd.pending && cmd.readNotWrite && stepping) begin
               next_cmd.targetRegAddr = steppedAddr; // (R12)
               next_cmd.pending = 1'b1; // (R12)
            end
         end else if (hitCmd) begin
            next_hostRdata = cmd;
         end else begin
            // unmapped and write-only window addresses read as zero
            next_hostRdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= SCSR_IDLE;
         cmd <= `SCSR_CMD_RESET;
         dataReg <= `SCSR_DATA_RESET;
         hostRdata <= 32'h0000_0000;
         hostRdValid <= 1'b0;
         fabReqInfo <= '0;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         dataReg <= next_dataReg;
         hostRdata <= next_hostRdata;
         hostRdValid <= next_hostRdValid;
         fabReqInfo <= next_fabReqInfo;
      end
   end

endmodule : scsr_bridge

`default_nettype wire

// ### rtl/scsr_lane_merge.sv
// byte-lane merge: takes new bytes where the enable is set, old bytes elsewhere
// purely combinational
`timescale 1ns/1ps
`default_nettype none

module scsr_lane_merge #(
   parameter int LANES = 4
) (
   input wire logic [LANES*8-1:0] oldWord,
   input wire logic [LANES*8-1:0] newWord,
   input wire logic [LANES-1:0] laneEn,
   output logic [LANES*8-1:0] merged
);

   genvar i;
   generate
      for (i = 0; i < LANES; i = i + 1) begin : g_lane
         assign merged[i*8 +: 8] = laneEn[i] ? newWord[i*8 +: 8] : oldWord[i*8 +: 8]; // (R16)
      end
   endgenerate

endmodule : scsr_lane_merge

`default_nettype wire
